// ===== cgr_pkg.sv
// package for the clock generator configuration slice: offsets, field positions, resets, types
// assumes byte-wide registers placed one per aligned 32-bit APB word
package cgr_pkg;
    localparam int NUM_SETS = 4;
    localparam int NUM_OUTS = 6;
    localparam int NUM_PLL_HOLD_SELECT = 3;
    // printed offsets are not multiples of four: kept as indices, byte address = 4 * index
    localparam logic [7:0] IDX_FB_SET0 = 8'h18;
    localparam logic [7:0] IDX_FB_SET1 = 8'h19;
    localparam logic [7:0] IDX_FB_SET2 = 8'h1A;
    localparam logic [7:0] IDX_FB_SET3 = 8'h1B;
    localparam logic [7:0] IDX_OFF_PIN = 8'h1C;
    localparam logic [7:0] IDX_HOLD_LOCK = 8'h1D;
    localparam logic [7:0] IDX_PLL_HOLD = 8'h1E;
    localparam logic [7:0] IDX_FB_LOW_SET0 = 8'h14;
    localparam logic [7:0] IDX_MULT_SET0 = 8'h40;
    localparam logic [7:0] IDX_MULT_SET1 = 8'h41;
    localparam logic [7:0] IDX_MULT_SET2 = 8'h42;
    localparam logic [7:0] IDX_MULT_SET3 = 8'h43;
    localparam logic [7:0] IDX_SEL = 8'h44;
    localparam logic [7:0] RST_FB = 8'h00;
    localparam logic [7:0] RST_OFF_PIN = 8'h00;
    localparam logic [7:0] RST_HOLD_LOCK = 8'h40;
    localparam logic [7:0] RST_PLL_HOLD = 8'h00;
    localparam logic [7:0] RST_FB_LOW = 8'h00;
    localparam logic [7:0] RST_SEL = 8'h00;
    localparam int ADD_LSB = 4;
    localparam int INT_HI_LSB = 0;
    localparam int POL_BIT = 7;
    localparam int FUNC_BIT = 6;
    localparam int LOCK_BIT = 6;
    localparam logic [7:0] HOLD_LOCK_MASK = 8'h7F;
    localparam logic [7:0] PLL_HOLD_MASK = 8'h07;
    localparam logic [7:0] SEL_MASK = 8'h07;
    localparam int SEL_SET_LSB = 0;
    localparam int SEL_MFC_BIT = 2;
    localparam logic [10:0] LOCK_COUNT_SHORT = 11'h008;
    localparam logic [10:0] LOCK_COUNT_LONG = 11'h400;
    localparam logic [1:0] STYLE_PARK_LOW = 2'h2;
    localparam logic [1:0] STYLE_PARK_HIGH = 2'h3;

    typedef struct packed {
        logic [NUM_OUTS-1:0] pin_disable;
        logic [NUM_OUTS-1:0] hold_enable;
        logic [NUM_PLL_HOLD_SELECT-1:0] pll_hold;
        logic off_pin_polarity;
        logic off_pin_function;
    } cgr_gate_cfg_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SETUP = 3'b010,
        ST_ACCESS = 3'b100
    } cgr_apb_state_type;
endpackage : cgr_pkg

// ===== cgr_mult.sv
// total feedback multiplier of one configuration set, in 1/64 units
// assumes static register inputs; purely combinational
`timescale 1ns/10ps
module cgr_mult (
    input wire logic [11:0] integer_count,
    input wire logic [3:0] add_count,
    input wire logic [5:0] spread_offset,
    input wire logic add_active,
    output logic [19:0] mult_x64
);
    import cgr_pkg::*;
    logic [13:0] whole;
    // add and the +1 apply only with a nonzero add count
    always_comb begin
        whole = {1'b0, integer_count, 1'b0};
        if (add_active) begin
            whole = 14'(whole + {10'h000, add_count} + 14'h0001);
        end
        mult_x64 = {whole, spread_offset};
    end
endmodule : cgr_mult

// ===== cgr_gate.sv
// output gating for six clocks from the global off pin and suspend pin
// assumes pins already synchronised; per-output pll association supplied
`timescale 1ns/10ps
module cgr_gate (
    input wire cgr_pkg::cgr_gate_cfg_type cfg,
    input wire logic [11:0] output_disable_style,
    input wire logic [11:0] output_pll_map,
    input wire logic off_pin,
    input wire logic general_input_three,
    input wire logic multi_function_control_mode,
    output logic [5:0] out_enable,
    output logic [5:0] out_hiz,
    output logic [5:0] out_park_value
);
    import cgr_pkg::*;
    logic off_active;
    logic hold_pin;
    assign off_active = cfg.off_pin_polarity ? ~off_pin : off_pin;
    assign hold_pin = multi_function_control_mode & general_input_three;
    genvar i;
    generate
        for (i = 0; i < NUM_OUTS; i++) begin : g_out
            logic pll_hit;
            logic off;
            logic [1:0] style;
            assign style = output_disable_style[2*i +: 2];
            assign pll_hit = (output_pll_map[2*i +: 2] < 2'(NUM_PLL_HOLD_SELECT)) && cfg.pll_hold[output_pll_map[2*i +: 2]];
            always_comb begin
                if (cfg.off_pin_function) begin
                    off = off_active;
                end else begin
                    off = (cfg.pin_disable[i] & off_active)
                        | (hold_pin & (pll_hit | cfg.hold_enable[i]));
                end
            end
            assign out_enable[i] = ~off;
            assign out_hiz[i] = off & ~style[1];
            assign out_park_value[i] = style == STYLE_PARK_HIGH;
        end
    endgenerate
endmodule : cgr_gate

// ===== cgr_regs.sv
// Functional notes
// - add count upper nibble, integer bits 11:8 lower
// - multiplier is 2N + A + 1 + offset/64; code adds A + 1 only for nonzero A, else 2N + offset/64
// - set zero applies in multi-function mode
// - polarity bit 0 active high, 1 low
// - per-output disable bit ties output to off pin
// - disable style: tristate, park low, park high
// - per-output hold bit suspends from suspend pin; code ignores suspend pin while function bit set
// - per-pll hold select suspends its outputs; code ignores suspend pin while function bit set
// - function bit makes off pin global shutdown
// - lock count 8 or 1024 input cycles
// APB slave holding the feedback-high and output gating registers of the clock generator
// assumes one pclk domain; off pin, suspend pin and input clock arrive asynchronous
`timescale 1ns/10ps
module cgr_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic off_pin,
    input wire logic general_input_three,
    input wire logic input_clock,
    input wire logic [7:0] pll0_spread_offset,
    input wire logic [11:0] output_disable_style,
    input wire logic [11:0] output_pll_map,
    output logic [5:0] out_enable,
    output logic [5:0] out_hiz,
    output logic [5:0] out_park_value,
    output logic [19:0] pll0_mult_x64,
    output logic [1:0] active_set,
    output logic input_good
);
    import cgr_pkg::*;

    logic [7:0] fb_high_q [NUM_SETS];
    logic [7:0] fb_low_q [NUM_SETS];
    logic [7:0] off_pin_ctl_q;
    logic [7:0] hold_lock_q;
    logic [7:0] pll_hold_q;
    logic [7:0] sel_q;
    cgr_apb_state_type state_q;
    logic [1:0] off_sync_q;
    logic [1:0] gin_sync_q;
    logic [1:0] clk_sync_q;
    logic clk_prev_q;
    logic [10:0] lock_cnt_q;
    logic input_good_q;
    logic [9:0] word_idx;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic [7:0] rd_byte;
    logic [1:0] set_sel;
    logic mfc_mode;
    logic [10:0] lock_target;
    cgr_gate_cfg_type gate_cfg;

    assign word_idx = paddr[11:2];
    assign mfc_mode = sel_q[SEL_MFC_BIT];

    // two-phase slave: answer in the first access cycle, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: state_q <= (psel && !penable) ? ST_SETUP : ST_IDLE;
                ST_SETUP: state_q <= ST_ACCESS;
                ST_ACCESS: state_q <= (psel && !penable) ? ST_SETUP : ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite & pstrb[0];
    // read data is captured in setup so it already stands when the access edge samples it
    assign rd_en = psel & ~penable & ~pwrite;

    always_comb begin
        hit = 1'b1;
        rd_byte = 8'h00;
        unique case (word_idx)
            10'(IDX_FB_SET0): rd_byte = fb_high_q[0];
            10'(IDX_FB_SET1): rd_byte = fb_high_q[1];
            10'(IDX_FB_SET2): rd_byte = fb_high_q[2];
            10'(IDX_FB_SET3): rd_byte = fb_high_q[3];
            10'(IDX_FB_LOW_SET0): rd_byte = fb_low_q[0];
            10'(IDX_FB_LOW_SET0 + 8'h01): rd_byte = fb_low_q[1];
            10'(IDX_FB_LOW_SET0 + 8'h02): rd_byte = fb_low_q[2];
            10'(IDX_FB_LOW_SET0 + 8'h03): rd_byte = fb_low_q[3];
            10'(IDX_OFF_PIN): rd_byte = off_pin_ctl_q;
            10'(IDX_HOLD_LOCK): rd_byte = hold_lock_q;
            10'(IDX_PLL_HOLD): rd_byte = pll_hold_q;
            10'(IDX_SEL): rd_byte = sel_q;
            10'(IDX_MULT_SET0): rd_byte = {1'b0, input_good_q, active_set, 4'h0};
            default: hit = 1'b0;
        endcase
    end

    assign pslverr = psel & penable & ~hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    // feedback-high per set: add count [7:4], integer [11:8] in [3:0]
    genvar s;
    generate
        for (s = 0; s < NUM_SETS; s++) begin : g_set
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fb_high_q[s] <= RST_FB;
                    fb_low_q[s] <= RST_FB_LOW;
                end else if (wr_en && state_q == ST_SETUP) begin
                    if (word_idx == 10'(IDX_FB_SET0 + 8'(s))) begin
                        fb_high_q[s] <= pwdata[7:0];
                    end
                    if (word_idx == 10'(IDX_FB_LOW_SET0 + 8'(s))) begin
                        fb_low_q[s] <= pwdata[7:0];
                    end
                end
            end
        end
    endgenerate

    // reserved bits are stored masked so they read zero even if the host slips
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_pin_ctl_q <= RST_OFF_PIN;
            hold_lock_q <= RST_HOLD_LOCK;
            pll_hold_q <= RST_PLL_HOLD;
            sel_q <= RST_SEL;
        end else if (wr_en && state_q == ST_SETUP) begin
            unique case (word_idx)
                10'(IDX_OFF_PIN): off_pin_ctl_q <= pwdata[7:0];
                10'(IDX_HOLD_LOCK): hold_lock_q <= pwdata[7:0] & HOLD_LOCK_MASK;
                10'(IDX_PLL_HOLD): pll_hold_q <= pwdata[7:0] & PLL_HOLD_MASK;
                10'(IDX_SEL): sel_q <= pwdata[7:0] & SEL_MASK;
                default: ;
            endcase
        end
    end

    // pins cross into pclk through two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_sync_q <= 2'h0;
            gin_sync_q <= 2'h0;
            clk_sync_q <= 2'h0;
            clk_prev_q <= 1'b0;
        end else begin
            off_sync_q <= {off_sync_q[0], off_pin};
            gin_sync_q <= {gin_sync_q[0], general_input_three};
            clk_sync_q <= {clk_sync_q[0], input_clock};
            clk_prev_q <= clk_sync_q[1];
        end
    end

    assign lock_target = hold_lock_q[LOCK_BIT] ? LOCK_COUNT_LONG : LOCK_COUNT_SHORT;

    // counts rising input edges; input only sampled, so it must be slower than pclk/2
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_cnt_q <= 11'h000;
            input_good_q <= 1'b0;
        end else if (clk_sync_q[1] && !clk_prev_q && !input_good_q) begin
            lock_cnt_q <= 11'(lock_cnt_q + 11'h001);
            input_good_q <= (11'(lock_cnt_q + 11'h001) >= lock_target);
        end
    end
    assign input_good = input_good_q;

    assign set_sel = mfc_mode ? 2'h0 : sel_q[SEL_SET_LSB +: 2];
    assign active_set = set_sel;

    cgr_mult u_mult (
        .integer_count({fb_high_q[set_sel][3:0], fb_low_q[set_sel]}),
        .add_count(fb_high_q[set_sel][7:ADD_LSB]),
        .spread_offset(pll0_spread_offset[5:0]),
        .add_active(fb_high_q[set_sel][7:ADD_LSB] != 4'h0),
        .mult_x64(pll0_mult_x64)
    );

    assign gate_cfg.pin_disable = off_pin_ctl_q[5:0];
    assign gate_cfg.hold_enable = hold_lock_q[5:0];
    assign gate_cfg.pll_hold = pll_hold_q[2:0];
    assign gate_cfg.off_pin_polarity = off_pin_ctl_q[POL_BIT];
    assign gate_cfg.off_pin_function = off_pin_ctl_q[FUNC_BIT];

    cgr_gate u_gate (
        .cfg(gate_cfg),
        .output_disable_style(output_disable_style),
        .output_pll_map(output_pll_map),
        .off_pin(off_sync_q[1]),
        .general_input_three(gin_sync_q[1]),
        .multi_function_control_mode(mfc_mode),
        .out_enable(out_enable),
        .out_hiz(out_hiz),
        .out_park_value(out_park_value)
    );
endmodule : cgr_regs

// ===== cgr_host.sv
// apb host model for the register slice, one transfer per call
// assumes a free-running pclk; waits on pready, bench timeout ends hangs
`timescale 1ns/10ps
module cgr_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end
    task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines inverted so stale values cannot pass
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : cgr_host

// ===== cgr_regs_assertions.sv
// output gating checks for the register slice
// assumes pins held still while judged; shadows track apb writes
`timescale 1ns/10ps
module cgr_regs_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic off_pin,
    input wire logic general_input_three,
    input wire logic [11:0] output_disable_style,
    input wire logic [11:0] output_pll_map,
    input wire logic [5:0] out_enable,
    input wire logic [5:0] out_hiz,
    input wire logic [5:0] out_park_value
);
    import cgr_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] oc_q;
    logic [5:0] hc_q, hi, lo, ps;
    logic [2:0] pc_q, quiet_q;
    logic [1:0] pin_q;
    logic mfc_q;
    wire wa = psel && penable && pwrite && pstrb[0] && pready;
    // pins pass a synchroniser, so judge only after a quiet spell
    wire settled = quiet_q == 3'h7 && {off_pin, general_input_three} == pin_q;
    wire act = off_pin ^ oc_q[POL_BIT];
    wire sus = mfc_q && general_input_three;
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            hi[i] = output_disable_style[2*i+1];
            lo[i] = output_disable_style[2*i];
            ps[i] = output_pll_map[2*i+:2] != 2'h3 && pc_q[output_pll_map[2*i+:2]];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_q <= RST_OFF_PIN;
            hc_q <= 6'h00;
            pc_q <= 3'h0;
            mfc_q <= 1'b0;
        end else if (wa) begin
            if (paddr == 12'h070) oc_q <= pwdata[7:0];
            if (paddr == 12'h074) hc_q <= pwdata[5:0];
            if (paddr == 12'h078) pc_q <= pwdata[2:0];
            if (paddr == 12'h110) mfc_q <= pwdata[SEL_MFC_BIT];
        end
    end
    // a pin edge reaches the quiet count one cycle late, so settled also compares with last cycle's pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet_q <= 3'h0;
            pin_q <= 2'h0;
        end else begin
            pin_q <= {off_pin, general_input_three};
            if (wa || {off_pin, general_input_three} != pin_q) quiet_q <= 3'h0;
            else if (!settled) quiet_q <= quiet_q + 3'h1;
        end
    end
    property p_shut;
        settled && oc_q[FUNC_BIT] && act |-> out_enable == 6'h00;
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown left outputs on");
    property p_pin_off;
        settled && !oc_q[FUNC_BIT] && act |-> (out_enable & oc_q[5:0]) == 6'h00;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin disable ignored");
    property p_pin_keep;
        settled && !oc_q[FUNC_BIT] && !sus |-> (out_enable | oc_q[5:0]) == 6'h3F;
    endproperty
    a_pin_keep: assert property (p_pin_keep) else $error("unlinked output stopped");
    property p_idle;
        settled && !act && !sus |-> out_enable == 6'h3F;
    endproperty
    a_idle: assert property (p_idle) else $error("outputs off with pin inactive");
    property p_hiz;
        settled |-> out_hiz == (~out_enable & ~hi);
    endproperty
    a_hiz: assert property (p_hiz) else $error("tristate wrong");
    property p_park;
        settled |-> ((out_park_value ^ lo) & ~out_enable & hi) == 6'h00;
    endproperty
    a_park: assert property (p_park) else $error("park level wrong");
    property p_hold;
        settled && sus |-> (out_enable & hc_q) == 6'h00;
    endproperty
    a_hold: assert property (p_hold) else $error("held output running");
    property p_pll_hold;
        settled && sus |-> (out_enable & ps) == 6'h00;
    endproperty
    a_pll_hold: assert property (p_pll_hold) else $error("pll hold ignored");
endmodule : cgr_regs_chk
bind cgr_regs cgr_regs_chk u_chk (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .pready(pready),
    .off_pin(off_pin),
    .general_input_three(general_input_three),
    .output_disable_style(output_disable_style),
    .output_pll_map(output_pll_map),
    .out_enable(out_enable),
    .out_hiz(out_hiz),
    .out_park_value(out_park_value)
);

// ===== tb.sv
// bench for the register slice: resets, readback, multiplier, gating, lock count
// assumes the host model speaks apb; pins driven here
`timescale 1ns/10ps
module tb;
    import cgr_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr, output_disable_style, output_pll_map;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic off_pin, general_input_three, input_clock, input_good;
    logic [7:0] pll0_spread_offset;
    logic [5:0] out_enable, out_hiz, out_park_value;
    logic [19:0] pll0_mult_x64;
    logic [1:0] active_set;
    int mismatches, comparisons, cycles;
    cgr_regs u_dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .off_pin(off_pin),
        .general_input_three(general_input_three),
        .input_clock(input_clock),
        .pll0_spread_offset(pll0_spread_offset),
        .output_disable_style(output_disable_style),
        .output_pll_map(output_pll_map),
        .out_enable(out_enable),
        .out_hiz(out_hiz),
        .out_park_value(out_park_value),
        .pll0_mult_x64(pll0_mult_x64),
        .active_set(active_set),
        .input_good(input_good)
    );
    cgr_host u_host (
        .pclk(pclk),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr)
    );
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task wr(input logic [11:0] a, input logic [7:0] d);
        u_host.xfer(1'b1, a, {24'h0, d}, q, e);
        @(posedge pclk);
    endtask : wr
    task rd(input logic [11:0] a, input logic [7:0] x);
        u_host.xfer(1'b0, a, 32'h0, q, e);
        check(q, {24'h0, x});
    endtask : rd
    task pins(input logic off, input logic gin);
        @(posedge pclk);
        off_pin <= off;
        general_input_three <= gin;
        repeat (10) @(posedge pclk);
    endtask : pins
    task clk_in(input int n);
        repeat (n) begin
            repeat (2) @(posedge pclk);
            input_clock <= ~input_clock;
        end
        repeat (6) @(posedge pclk);
    endtask : clk_in
    task wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        presetn = 1'b0;
        off_pin = 1'b0;
        general_input_three = 1'b0;
        input_clock = 1'b0;
        pll0_spread_offset = 8'h00;
        output_disable_style = 12'hE4E;
        output_pll_map = 12'h4E4;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) rd(12'h060 + 12'(4 * i), (i == 5) ? 8'h40 : 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(12'h060 + 12'(4 * i), 8'h5A + 8'(i));
            rd(12'h060 + 12'(4 * i), 8'h5A + 8'(i));
        end
        wr(12'h074, 8'hFF);
        rd(12'h074, 8'h7F);
        wr(12'h078, 8'hFF);
        rd(12'h078, 8'h07);
        wr(12'h078, 8'h00);
        u_host.xfer(1'b1, 12'h07C, 32'h0000_00FF, q, e);
        check({31'h0, e}, 32'h1);
        wr(12'h050, 8'h10);
        rd(12'h050, 8'h10);
        wr(12'h060, 8'h05);
        check(32'(pll0_mult_x64), 2 * 32'h510 * 64);
        wr(12'h060, 8'h35);
        pll0_spread_offset <= 8'h05;
        @(posedge pclk);
        check(32'(pll0_mult_x64), (2 * 32'h510 + 32'h4) * 64 + 32'h5);
        wr(12'h110, 8'h02);
        check(32'(active_set), 32'h2);
        wr(12'h110, 8'h06);
        rd(12'h110, 8'h06);
        check(32'(active_set), 32'h0);
        wr(12'h070, 8'h0F);
        pins(1'b1, 1'b0);
        check(32'(out_enable), 32'h30);
        check(32'(out_hiz), 32'h0C);
        check(32'(out_park_value & 6'h03), 32'h2);
        pins(1'b0, 1'b0);
        check(32'(out_enable), 32'h3F);
        wr(12'h070, 8'h8F);
        pins(1'b0, 1'b0);
        check(32'(out_enable), 32'h30);
        wr(12'h070, 8'hC0);
        pins(1'b0, 1'b0);
        check(32'(out_enable), 32'h00);
        wr(12'h070, 8'h00);
        wr(12'h074, 8'h41);
        pins(1'b0, 1'b1);
        check(32'(out_enable), 32'h3E);
        wr(12'h078, 8'h04);
        pins(1'b0, 1'b1);
        check(32'(out_enable), 32'h3A);
        clk_in(40);
        check({31'h0, input_good}, 32'h0);
        wr(12'h074, 8'h00);
        clk_in(40);
        check({31'h0, input_good}, 32'h1);
        rd(12'h100, 8'h40);
        wrap_up();
    end
endmodule : tb
